/* File: core/pll_control_interface.sv */
// control and status model of one clock synthesizer seen from the fabric
// assumes fabric drives select, reset and settings on core_clk_i; reference pins are async
//
// What this block does
// - reference chosen from four inputs by select
// - reset low resets; release starts lock acquisition
// - lock rises, falls on loss, holds without reference
// - lock is registered on core_clk_i; consumers filter
// - pre, multiplier, post and output divider stages
// - internal feedback output frequency counter relation
// - local/core feedback includes output-0 divider, limit 255
// - three output clocks for the global network
// - one instance may use differential reference
// - phase alignment only in local/core feedback
// - phase shift allowed only for divider 2 or 4
`timescale 1ns/100ps
module pll_control_interface #(
  parameter bit LVDS_REF_EN = 1'b0,
  parameter int unsigned LOCK_EDGES = pll_cfg_pkg::LOCK_REF_EDGES,
  parameter int unsigned FB_MISS = pll_cfg_pkg::FB_MISS_EDGES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // reference clocks and selection
  input wire logic [pll_cfg_pkg::NUM_REF-1:0] ref_clk_in_i,
  input wire logic lvds_ref_clk_i,
  input wire logic [1:0] ref_clk_select_i,
  // synthesizer control from fabric
  input wire logic pll_reset_n_i,
  input wire logic feedback_clk_in_i,
  input wire pll_cfg_pkg::synth_cfg_type cfg_i,
  // synthesized clocks and status
  output logic synth_clk_out_0_o,
  output logic synth_clk_out_1_o,
  output logic synth_clk_out_2_o,
  output pll_cfg_pkg::synth_status_type status_o
);
  import pll_cfg_pkg::*;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_type;

  lock_state_type state_q;
  lock_state_type state_d;
  logic [NUM_REF-1:0] ref_s1_q;
  logic [NUM_REF-1:0] ref_s2_q;
  logic [NUM_REF-1:0] ref_s3_q;
  logic [2:0] fb_sync_q;
  logic [7:0] rst_low_q;
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic [LOCK_CNT_W-1:0] fb_miss_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic tick_q;
  logic tick_d;
  logic [1:0] sel_q;
  synth_cfg_type cfg_snap_q;
  synth_status_type status_q;
  logic [NUM_OUT-1:0] out_clk;

  // one reference position may take the differential receive buffer
  wire [NUM_REF-1:0] ref_raw = LVDS_REF_EN ? {lvds_ref_clk_i, ref_clk_in_i[NUM_REF-2:0]}
                                           : ref_clk_in_i;

  // three-stage synchronisers for every reference and for feedback
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ref_s1_q <= '0;
      ref_s2_q <= '0;
      ref_s3_q <= '0;
      fb_sync_q <= '0;
    end else begin
      ref_s1_q <= ref_raw;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      fb_sync_q <= {fb_sync_q[1:0], feedback_clk_in_i};
    end
  end

  // rising edge of the selected reference
  wire ref_edge = ref_s2_q[ref_clk_select_i] & ~ref_s3_q[ref_clk_select_i];
  wire fb_edge = fb_sync_q[1] & ~fb_sync_q[2];

  // reset taken once held low for the minimum pulse
  wire [7:0] rst_min = 8'(RST_MIN_CYC);
  wire synth_in_reset = !pll_reset_n_i && (rst_low_q + 1'b1 >= rst_min);

  // counter stage values
  wire [3:0] post_val = 4'(1 << cfg_i.post_code);
  wire [ODIV_W-1:0] fbk_div = cfg_i.out_div[0];
  wire loop_mode = (cfg_i.fb_mode != FB_INTERNAL);
  wire [LOOP_W-1:0] loop_prod = LOOP_W'(cfg_i.mult) * LOOP_W'(post_val) * LOOP_W'(fbk_div);
  wire multi_out = (cfg_i.out_en[0] & cfg_i.out_en[1]) | (cfg_i.out_en[0] & cfg_i.out_en[2])
                 | (cfg_i.out_en[1] & cfg_i.out_en[2]);

  // phase shift legality per output
  logic [NUM_OUT-1:0] phase_ok;
  logic [NUM_OUT-1:0] div_ok;
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_chk
    wire [PHASE_W-1:0] ph = cfg_i.phase[i];
    wire ph2 = (ph == PH_90) || (ph == PH_180) || (ph == PH_270);
    wire ph4 = (ph == PH_45) || (ph == PH_90) || (ph == PH_135);
    assign phase_ok[i] = !cfg_i.out_en[i] || (ph == PH_0)
                       || ((cfg_i.out_div[i] == ODIV_PHASE_2) && ph2)
                       || ((cfg_i.out_div[i] == ODIV_PHASE_4) && ph4);
    assign div_ok[i] = !cfg_i.out_en[i] || (cfg_i.out_div[i] != '0);
  end

  // settings check: loop product, post divider and mode
  wire cfg_ok = (cfg_i.mult != '0) && (cfg_i.pre_div != '0) && (&div_ok) && (&phase_ok)
              && !(multi_out && (cfg_i.post_code == 2'h0))
              && (cfg_i.fb_mode == FB_INTERNAL || cfg_i.fb_mode == FB_LOCAL
                  || cfg_i.fb_mode == FB_CORE)
              && (!loop_mode || (loop_prod <= LOOP_PRODUCT_MAX))
              && (!loop_mode || (fbk_div != '0));

  // rate numerator and denominator of the post-divided frequency
  wire [ACC_W-1:0] rate_num = loop_mode ? ACC_W'(LOOP_W'(cfg_i.mult) * LOOP_W'(fbk_div))
                                        : ACC_W'(cfg_i.mult);
  // in loop modes the post divider sits inside the loop and cancels out
  wire [ACC_W-1:0] rate_den = loop_mode ? ACC_W'(cfg_i.pre_div)
                                        : ACC_W'(cfg_i.pre_div) * ACC_W'(post_val);
  wire [ACC_W-1:0] acc_sum = acc_q + (ref_edge ? rate_num : '0);
  wire acc_hit = (rate_den != '0) && (acc_sum >= rate_den);
  wire [ACC_W-1:0] acc_sub = acc_hit ? acc_sum - rate_den : acc_sum;

  // accumulator reloads with rate_den on reaching ACC_LIMIT when the rate exceeds one tick per core cycle
  assign acc_d = (acc_sub >= ACC_LIMIT) ? rate_den : acc_sub;
  assign tick_d = acc_hit && (state_q == ST_LOCKED);

  // lock decisions, advanced on reference edges except entering and leaving reset
  wire cfg_changed = (cfg_i != cfg_snap_q) || (ref_clk_select_i != sel_q);
  wire fb_lost = (cfg_i.fb_mode == FB_CORE) && (fb_miss_q >= LOCK_CNT_W'(FB_MISS));
  wire lock_done = (lock_cnt_q + 1'b1 >= LOCK_CNT_W'(LOCK_EDGES)) && cfg_ok && !fb_lost;

  // lock state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (!synth_in_reset) begin
          state_d = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (ref_edge && lock_done && !cfg_changed) begin
          state_d = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (ref_edge && (cfg_changed || !cfg_ok || fb_lost)) begin
          state_d = ST_ACQUIRE;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (synth_in_reset) begin
      state_d = ST_RESET;
    end
  end

  // reset pulse width counter
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || pll_reset_n_i) begin
      rst_low_q <= '0;
    end else if (rst_low_q != 8'hFF) begin
      rst_low_q <= rst_low_q + 1'b1;
    end
  end

  // state, settings snapshot and acquisition counters
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_q <= ST_RESET;
      cfg_snap_q <= '0;
      sel_q <= '0;
      lock_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_LOCKED && (state_d != ST_LOCKED)
          && (cfg_changed || state_q == ST_RESET)) begin
        cfg_snap_q <= cfg_i;
        sel_q <= ref_clk_select_i;
        lock_cnt_q <= '0;
      end else if (state_q == ST_ACQUIRE && ref_edge && lock_cnt_q != '1) begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end else if (state_d == ST_ACQUIRE && state_q == ST_LOCKED) begin
        lock_cnt_q <= '0;
      end
    end
  end

  // feedback watchdog in reference edges, core feedback only
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || state_q == ST_RESET || fb_edge) begin
      fb_miss_q <= '0;
    end else if (ref_edge && fb_miss_q != '1) begin
      fb_miss_q <= fb_miss_q + 1'b1;
    end
  end

  // synthesized rate accumulator
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || state_q == ST_RESET) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  // registered status; lock low during reset
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      status_q <= '0;
    end else begin
      status_q.locked <= (state_d == ST_LOCKED);
      status_q.cfg_error <= !cfg_ok;
      status_q.fb_missing <= fb_lost;
    end
  end

  // three output dividers, stopped until lock
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    synth_out_divider #(
      .DIV_W(ODIV_W),
      .PH_W(PHASE_W)
    ) u_div (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .run_i(cfg_i.out_en[i] && (state_q == ST_LOCKED)),
      .tick_i(tick_q),
      .div_i(cfg_i.out_div[i]),
      .phase_i(cfg_i.phase[i]),
      .clk_o(out_clk[i])
    );
  end

  assign synth_clk_out_0_o = out_clk[0];
  assign synth_clk_out_1_o = out_clk[1];
  assign synth_clk_out_2_o = out_clk[2];
  assign status_o = status_q;
endmodule

/* File: core/synth_out_divider.sv */
// one output divider with optional phase offset
// assumes tick_i is a one-cycle pulse per post-divided synthesizer period
`timescale 1ns/100ps
module synth_out_divider #(
  parameter int unsigned DIV_W = 9,
  parameter int unsigned PH_W = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // control
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [DIV_W-1:0] div_i,
  input wire logic [PH_W-1:0] phase_i,
  // divided clock
  output logic clk_o
);
  import pll_cfg_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic clk_q;
  logic clk_d;
  wire [3:0] eighths = (phase_i == PH_270) ? EIGHTHS_270 : {1'b0, phase_i};
  wire [DIV_W+3:0] off_full = (DIV_W+4)'(div_i) * (DIV_W+4)'(eighths);
  wire [DIV_W-1:0] offset = DIV_W'(off_full >> 3);
  wire [DIV_W:0] pos_raw = (DIV_W+1)'(cnt_q) + (DIV_W+1)'(offset);
  wire [DIV_W:0] pos = (pos_raw >= (DIV_W+1)'(div_i)) ? pos_raw - (DIV_W+1)'(div_i) : pos_raw;
  wire [DIV_W:0] half = ((DIV_W+1)'(div_i) + 1'b1) >> 1;
  wire single = (div_i == DIV_W'(1));

  // period counter and output level, low while stopped
  assign cnt_d = (cnt_q + 1'b1 >= div_i) ? '0 : cnt_q + 1'b1;
  assign clk_d = single ? ~clk_q : (pos < half);

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !run_i) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else if (tick_i) begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign clk_o = clk_q;
endmodule

/* File: dv/fabric_ref_model.sv */
// reference sources and feedback routing on the fabric side
// assumes the bench gates each source; a halted source keeps its level
`timescale 1ns/100ps
module fabric_ref_model (
  // controls
  input wire logic [3:0] run_i,
  input wire logic fb_en_i,
  // synthesizer side
  input wire logic clk_out_0_i,
  output logic [3:0] ref_clk_o,
  output logic fb_clk_o
);
  // unrelated periods of 6, 8, 10 and 12 core cycles
  for (genvar i = 0; i < 4; i++) begin : g_src
    logic q = 1'b0;
    always #(30 + 10 * i) if (run_i[i]) q = !q;
    assign ref_clk_o[i] = q;
  end
  // output 0 routed back as feedback
  assign fb_clk_o = fb_en_i & clk_out_0_i;
endmodule

/* File: dv/pll_ctl_properties.sv */
// port checker for the synthesizer control block
// assumes one core clock and binds onto pll_control_interface
`timescale 1ns/100ps
module pll_ctl_properties #(
  parameter int unsigned LOCK_EDGES = 4,
  parameter int unsigned FB_MISS = 4
) (
  // clock and inputs
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [pll_cfg_pkg::NUM_REF-1:0] ref_clk_in_i,
  input wire logic pll_reset_n_i,
  input wire pll_cfg_pkg::synth_cfg_type cfg_i,
  // outputs
  input wire logic synth_clk_out_0_o,
  input wire logic synth_clk_out_1_o,
  input wire logic synth_clk_out_2_o,
  input wire pll_cfg_pkg::synth_status_type status_o
);
  import pll_cfg_pkg::*;
  logic [7:0] up_cnt_q;
  logic [7:0] up_cnt_d;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // cycles since synthesizer reset released, saturating
  assign up_cnt_d = !pll_reset_n_i ? 8'h00 : (up_cnt_q == 8'hFF) ? up_cnt_q : up_cnt_q + 8'h01;
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      up_cnt_q <= 8'h00;
    end else begin
      up_cnt_q <= up_cnt_d;
    end
  end
  a_rst_clears:
    assert property ($rose(resetn_i) |-> status_o == 3'h0 && !synth_clk_out_0_o)
      else $error("outputs not clear after reset");
  a_pllrst_unlock:
    assert property (!pll_reset_n_i |=> !status_o.locked) else $error("locked in reset");
  a_idle_unlocked:
    assert property (!status_o.locked |=> !(synth_clk_out_0_o || synth_clk_out_1_o
      || synth_clk_out_2_o)) else $error("clock runs without lock");
  a_rise_in_lock:
    assert property ($rose(synth_clk_out_1_o) |-> $past(status_o.locked))
      else $error("clock rose while unlocked");
  a_hold_noref:
    assert property ((pll_reset_n_i && $stable(ref_clk_in_i))[*8] |-> $stable(status_o.locked))
      else $error("lock moved without reference");
  a_lock_late:
    assert property ($rose(status_o.locked) |-> up_cnt_q >= 8'(LOCK_EDGES))
      else $error("lock too early");
  a_post_err:
    assert property (cfg_i.post_code == 2'h0 && $countones(cfg_i.out_en) > 1
      |=> status_o.cfg_error) else $error("post divider error missed");
  a_loop_limit:
    assert property (cfg_i.fb_mode inside {FB_LOCAL, FB_CORE} && (32'(cfg_i.mult)
      << cfg_i.post_code) * 32'(cfg_i.out_div[0]) > 32'hFF |=> status_o.cfg_error)
      else $error("loop limit error missed");
  a_phase_err:
    assert property (cfg_i.out_div[1] == ODIV_PHASE_4 && cfg_i.phase[1] == PH_180
      |=> status_o.cfg_error) else $error("phase error missed");
endmodule
bind pll_control_interface pll_ctl_properties #(.LOCK_EDGES(LOCK_EDGES), .FB_MISS(FB_MISS))
  u_props (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ref_clk_in_i(ref_clk_in_i),
  .pll_reset_n_i(pll_reset_n_i), .cfg_i(cfg_i), .synth_clk_out_0_o(synth_clk_out_0_o),
  .synth_clk_out_1_o(synth_clk_out_1_o), .synth_clk_out_2_o(synth_clk_out_2_o),
  .status_o(status_o));

/* File: dv/testbench.sv */
// self-checking bench for the synthesizer control block
// assumes the package constants and a 100 MHz core clock
`timescale 1ns/100ps
module testbench;
  import pll_cfg_pkg::*;
  localparam synth_cfg_type BASE = '{mult: 8'h04, pre_div: 4'h1, post_code: 2'h1,
    fb_mode: FB_INTERNAL, out_en: 3'h7, out_div: {9'h008, 9'h004, 9'h002}, phase: 9'h000};
  logic core_clk;
  logic resetn;
  logic pll_pll_reset_n;
  logic [1:0] sel;
  logic [3:0] run;
  logic fb_en;
  logic [3:0] refs;
  logic fb_clk;
  logic [2:0] clk_out;
  synth_cfg_type cfg;
  synth_status_type st;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // block, fabric model; a single instance, never cascaded
  pll_control_interface #(.LOCK_EDGES(4), .FB_MISS(4)) DUT (.core_clk_i(core_clk),
    .resetn_i(resetn), .ref_clk_in_i(refs), .lvds_ref_clk_i(1'b0), .ref_clk_select_i(sel),
    .pll_reset_n_i(pll_pll_reset_n), .feedback_clk_in_i(fb_clk), .cfg_i(cfg),
    .synth_clk_out_0_o(clk_out[0]), .synth_clk_out_1_o(clk_out[1]),
    .synth_clk_out_2_o(clk_out[2]), .status_o(st));
  fabric_ref_model u_fab (.run_i(run), .fb_en_i(fb_en), .clk_out_0_i(clk_out[0]),
    .ref_clk_o(refs), .fb_clk_o(fb_clk));
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // relock changes settings and select under synthesizer reset
  task automatic relock(input logic [1:0] s, input synth_cfg_type c);
    pll_pll_reset_n = 1'b0;
    sel = s;
    cfg = c;
    step(20);
    pll_pll_reset_n = 1'b1;
  endtask
  task automatic wait_lock(output logic got);
    for (int k = 0; k < 200 && st.locked !== 1'b1; k++) step(1);
    got = st.locked;
  endtask
  task automatic t_reset();
    step(1);
    check("status", st, 3'h0);
    check("clocks", clk_out, 3'h0);
    $display("reset done");
  endtask
  // each select takes its own source; a halted source never locks
  task automatic t_select();
    logic got;
    for (int i = 0; i < 4; i++) begin
      run = 4'h1 << i;
      relock(2'(i), BASE);
      wait_lock(got);
      check("lock", got, 1'b1);
      relock(2'(i + 1), BASE);
      step(150);
      check("nolock", st.locked, 1'b0);
    end
    run = 4'hF;
    $display("select done");
  endtask
  // lock holds while the reference is halted, drops once it returns
  task automatic t_hold();
    logic got;
    relock(2'h0, BASE);
    wait_lock(got);
    run = 4'h0;
    step(8);
    cfg.fb_mode = fb_mode_type'(2'b11);
    step(40);
    check("held", st.locked, 1'b1);
    run = 4'hF;
    step(60);
    check("lost", st.locked, 1'b0);
    $display("hold done");
  endtask
  // output rates over 100 reference periods in all three feedback modes
  task automatic t_modes();
    logic got;
    int cnt[3];
    int e;
    logic [2:0] prev;
    synth_cfg_type c;
    for (int m = 0; m < 3; m++) begin
      c = BASE;
      c.fb_mode = fb_mode_type'(m);
      c.mult = (m == 0) ? 8'h04 : 8'h02;
      relock(2'h0, c);
      wait_lock(got);
      step(20);
      cnt = '{0, 0, 0};
      prev = clk_out;
      repeat (600) begin
        step(1);
        for (int j = 0; j < 3; j++) cnt[j] += int'(clk_out[j] & !prev[j]);
        prev = clk_out;
      end
      for (int j = 0; j < 3; j++) begin
        if (m == 0) begin
          e = 100 * int'(c.mult)
            / (int'(c.pre_div) * (1 << c.post_code) * int'(c.out_div[j]));
        end else begin
          e = 100 * int'(c.mult) * int'(c.out_div[0])
            / (int'(c.pre_div) * int'(c.out_div[j]));
        end
        check("rate", cnt[j] >= e - 2 && cnt[j] <= e + 2, 1'b1);
      end
    end
    $display("modes done");
  endtask
  // a quarter-period shift on output 1 against an unshifted twin output
  task automatic t_phase();
    logic got;
    int diff;
    synth_cfg_type c;
    c = BASE;
    c.mult = 8'h02;
    c.out_div[2] = 9'h004;
    c.phase[1] = PH_90;
    relock(2'h0, c);
    wait_lock(got);
    check("ph_lock", got, 1'b1);
    step(20);
    diff = 0;
    repeat (600) begin
      step(1);
      diff += int'(clk_out[1] != clk_out[2]);
    end
    check("phase", diff >= 280 && diff <= 320, 1'b1);
    $display("phase done");
  endtask
  // core feedback left unconnected is reported
  task automatic t_fbmiss();
    logic seen;
    synth_cfg_type c;
    c = BASE;
    c.fb_mode = FB_CORE;
    fb_en = 1'b0;
    seen = 1'b0;
    relock(2'h0, c);
    repeat (300) begin
      step(1);
      seen = seen | st.fb_missing;
    end
    check("fbmiss", seen, 1'b1);
    fb_en = 1'b1;
    $display("fbmiss done");
  endtask
  // legal and illegal counter and phase settings
  task automatic t_cfg();
    synth_cfg_type c;
    logic bad;
    for (int k = 0; k < 5; k++) begin
      c = BASE;
      c.fb_mode = (k == 0) ? FB_LOCAL : FB_INTERNAL;
      c.mult = (k < 2) ? 8'h40 : 8'h04;
      c.post_code = (k < 2) ? 2'h2 : (k == 2) ? 2'h0 : 2'h1;
      c.phase[1] = (k == 3) ? PH_180 : (k == 4) ? PH_135 : PH_0;
      bad = (k == 0 || k == 2 || k == 3);
      relock(2'h0, c);
      step(150);
      check("cfg_error", st.cfg_error, bad);
      check("cfg_lock", st.locked, !bad);
    end
    $display("cfg done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    pll_pll_reset_n = 1'b0;
    sel = 2'h0;
    run = 4'hF;
    fb_en = 1'b1;
    cfg = BASE;
    step(6);
    resetn = 1'b1;
    t_reset();
    t_select();
    t_hold();
    t_modes();
    t_phase();
    t_fbmiss();
    t_cfg();
    print_verdict();
  end
endmodule

/* File: pkg/pll_cfg_pkg.sv */
// constants, modes and carrier types for the clock synthesizer control block
// assumes a single 100 MHz core clock; shared by the control block and its output dividers
package pll_cfg_pkg;

  // core clock and reset pulse timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_MIN_NS = 10;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter widths and limits
  localparam int unsigned NUM_REF = 4;
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned MUL_W = 8;
  localparam int unsigned PRE_W = 4;
  localparam int unsigned ODIV_W = 9;
  localparam int unsigned PHASE_W = 3;
  localparam int unsigned LOOP_W = 21;
  localparam int unsigned ACC_W = 18;
  localparam logic [LOOP_W-1:0] LOOP_PRODUCT_MAX = 21'h0000FF;
  localparam logic [ACC_W-1:0] ACC_LIMIT = 18'h20000;

  // output divider values that permit phase shift
  localparam logic [ODIV_W-1:0] ODIV_PHASE_2 = 9'h002;
  localparam logic [ODIV_W-1:0] ODIV_PHASE_4 = 9'h004;

  // lock acquisition defaults, counted in reference edges
  localparam int unsigned LOCK_CNT_W = 16;
  localparam int unsigned LOCK_REF_EDGES = 64;
  localparam int unsigned FB_MISS_EDGES = 64;

  // feedback routing modes
  typedef enum logic [1:0] {
    FB_INTERNAL = 2'b00,
    FB_LOCAL = 2'b01,
    FB_CORE = 2'b10
  } fb_mode_type;

  // output phase shift codes, in steps of 45 degrees except the last
  typedef enum logic [PHASE_W-1:0] {
    PH_0 = 3'h0,
    PH_45 = 3'h1,
    PH_90 = 3'h2,
    PH_135 = 3'h3,
    PH_180 = 3'h4,
    PH_270 = 3'h5
  } phase_type;

  // eighths of a period for the 270 degree code; other codes equal their value
  localparam logic [3:0] EIGHTHS_270 = 4'h6;

  // counter and output settings from fabric
  typedef struct packed {
    logic [MUL_W-1:0] mult;
    logic [PRE_W-1:0] pre_div;
    logic [1:0] post_code;
    fb_mode_type fb_mode;
    logic [NUM_OUT-1:0] out_en;
    logic [NUM_OUT-1:0][ODIV_W-1:0] out_div;
    logic [NUM_OUT-1:0][PHASE_W-1:0] phase;
  } synth_cfg_type;

  // status seen by fabric
  typedef struct packed {
    logic locked;
    logic cfg_error;
    logic fb_missing;
  } synth_status_type;

endpackage
